// [host_model.sv]
// Host side of the serial link: chip-select, serial clock, power-down request.
// Assumes serial data is settled well before each serial clock rising edge.
module host_model (
    output logic cs_b_o,
    output logic sclk_o,
    output logic pd_req_o,
    input wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_b_o = 1'b1;
        sclk_o = 1'b0;
        pd_req_o = 1'b0;
    end

    // ****************************************************
    // One frame of n clocks, 160 ns period, clock idle low
    // ****************************************************
    task automatic frame(input int n, input logic pd, output logic [31:0] cap);
        cap = 32'h0000_0000;
        pd_req_o = pd;
        cs_b_o = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            cap[31-i] = sdo_i;
            #80;
            sclk_o = 1'b0;
            #80;
        end
        // Clock halted after the last falling edge
        cs_b_o = 1'b1;
    endtask
endmodule // host_model

// [link_count_if.sv]
// Gray-coded serial clock edge counts passed from the link domain to the core.
// Assumes the consumer synchronises every bit before use.
interface link_count_if;
    logic [5:0] rise_gray;
    logic [5:0] fall_gray;
    modport link (output rise_gray, output fall_gray);
    modport core (input rise_gray, input fall_gray);
endinterface

// [link_edge_counter.sv]
// Counts serial clock rising and falling edges within one chip-select frame.
// Assumes chip-select high holds both counts cleared; counts saturate.
module link_edge_counter (
    input wire logic sclk_i,
    input wire logic cs_b_i,
    link_count_if.link cnt
);

    logic [5:0] rise_bin;
    logic [5:0] fall_bin;

    assign rise_bin = sar_seq_pkg::gray_to_bin(cnt.rise_gray);
    assign fall_bin = sar_seq_pkg::gray_to_bin(cnt.fall_gray);

    // ****************************************************
    // Rising edges, cleared by the frame's own end
    // ****************************************************
    always_ff @(posedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            cnt.rise_gray <= sar_seq_pkg::CNT_RESET;
        end else if (rise_bin != sar_seq_pkg::CNT_MAX) begin
            cnt.rise_gray <= sar_seq_pkg::bin_to_gray(rise_bin + 6'h01);
        end
    end

    // ****************************************************
    // Falling edges
    // ****************************************************
    always_ff @(negedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            cnt.fall_gray <= sar_seq_pkg::CNT_RESET;
        end else if (fall_bin != sar_seq_pkg::CNT_MAX) begin
            cnt.fall_gray <= sar_seq_pkg::bin_to_gray(fall_bin + 6'h01);
        end
    end

endmodule // link_edge_counter

// [sar_adc_frame_sequencer.sv]
// Frame sequencer of a SAR converter: sampling, conversion, serial readout, power-down.
// Assumes a host-driven chip-select and serial clock; the sample value input is quasi-static.
module sar_adc_frame_sequencer (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic power_down_request_i,
    input wire logic [11:0] sample_value_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic [11:0] result_o,
    output logic powered_down_o,
    output logic fully_powered_o,
    output logic converting_o,
    output logic acquiring_o,
    output logic long_frame_o
);

    localparam int RES = sar_seq_pkg::RESOLUTION;
    localparam int WB = sar_seq_pkg::WORD_BITS;

    // ****************************************************
    // Link-domain edge counters
    // ****************************************************
    link_count_if cnt_if ();

    link_edge_counter u_link (
        .sclk_i(sclk_i),
        .cs_b_i(cs_b_i),
        .cnt(cnt_if.link)
    );

    // ****************************************************
    // Declarations
    // ****************************************************
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic pd_meta;
    logic pd_sync;
    logic [RES-1:0] samp_meta;
    logic [RES-1:0] samp_sync;
    logic [5:0] rise_meta;
    logic [5:0] rise_sync;
    logic [5:0] fall_meta;
    logic [5:0] fall_sync;
    logic [5:0] rise_bin;
    logic [5:0] fall_bin;
    logic [5:0] rise_seen;
    logic [5:0] fall_seen;
    logic rise_evt;
    logic fall_evt;
    logic frame_start;
    logic frame_end;
    logic [RES-1:0] sample_hold;
    logic [RES-1:0] sar;
    logic [RES-1:0] next_sar;
    logic [RES-1:0] trial;
    logic [5:0] bit_pos;
    logic sar_step;
    logic conv_done;
    logic [WB-1:0] shreg;
    logic [WB-1:0] next_shreg;
    logic pd_armed;
    sar_seq_pkg::power_state_t pwr;
    sar_seq_pkg::power_state_t next_pwr;
    logic [6:0] wake_cnt;

    function automatic logic [WB-1:0] justify(input logic [RES-1:0] r);
        return {r, {(WB - RES){1'b0}}};
    endfunction

    // ****************************************************
    // Synchronisers
    // ****************************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_b_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
            samp_meta <= '0;
            samp_sync <= '0;
        end else begin
            pd_meta <= power_down_request_i;
            pd_sync <= pd_meta;
            samp_meta <= sample_value_i;
            samp_sync <= samp_meta;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_meta <= sar_seq_pkg::CNT_RESET;
            rise_sync <= sar_seq_pkg::CNT_RESET;
            fall_meta <= sar_seq_pkg::CNT_RESET;
            fall_sync <= sar_seq_pkg::CNT_RESET;
        end else begin
            rise_meta <= cnt_if.rise_gray;
            rise_sync <= rise_meta;
            fall_meta <= cnt_if.fall_gray;
            fall_sync <= fall_meta;
        end
    end

    // ****************************************************
    // Edge events
    // ****************************************************
    // A count that drops at the frame's end is never mistaken for an edge
    assign rise_bin = sar_seq_pkg::gray_to_bin(rise_sync);
    assign fall_bin = sar_seq_pkg::gray_to_bin(fall_sync);
    assign rise_evt = !cs_sync && (rise_bin == rise_seen + 6'h01);
    assign fall_evt = !cs_sync && (fall_bin == fall_seen + 6'h01);
    assign frame_start = cs_prev && !cs_sync;
    assign frame_end = !cs_prev && cs_sync;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rise_seen <= sar_seq_pkg::CNT_RESET;
        end else if (cs_sync) begin
            rise_seen <= sar_seq_pkg::CNT_RESET;
        end else if (rise_evt) begin
            rise_seen <= rise_bin;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fall_seen <= sar_seq_pkg::CNT_RESET;
        end else if (cs_sync) begin
            fall_seen <= sar_seq_pkg::CNT_RESET;
        end else if (fall_evt) begin
            fall_seen <= fall_bin;
        end
    end

    // ****************************************************
    // Sample capture and conversion
    // ****************************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_hold <= '0;
        end else if (frame_start) begin
            sample_hold <= samp_sync;
        end
    end

    assign bit_pos = sar_seq_pkg::CONV_DONE_RISE - rise_bin;
    assign trial = sar | (RES'(1) << bit_pos[3:0]);
    assign sar_step = rise_evt && converting_o &&
                      (rise_bin >= sar_seq_pkg::CONV_FIRST_RISE) &&
                      (rise_bin <= sar_seq_pkg::CONV_DONE_RISE);
    assign conv_done = sar_step && (rise_bin == sar_seq_pkg::CONV_DONE_RISE);

    always_comb begin
        next_sar = sar;
        if (sar_step && (sample_hold >= trial)) begin
            next_sar = trial;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sar <= '0;
        end else if (frame_start) begin
            sar <= '0;
        end else begin
            sar <= next_sar;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            converting_o <= 1'b0;
        end else if (frame_start) begin
            converting_o <= 1'b1;
        end else if (conv_done || frame_end) begin
            converting_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acquiring_o <= 1'b1;
        end else if (frame_start) begin
            acquiring_o <= 1'b0;
        end else if (conv_done || frame_end) begin
            acquiring_o <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_o <= '0;
        end else if (conv_done) begin
            result_o <= next_sar;
        end
    end

    // ****************************************************
    // Serial readout
    // ****************************************************
    always_comb begin
        next_shreg = shreg;
        if (frame_start) begin
            // A frame after a short frame hands out the previous result, after a long frame zeros
            next_shreg = long_frame_o ? sar_seq_pkg::WORD_RESET : justify(result_o);
        end else if (fall_evt && (fall_bin == sar_seq_pkg::RELOAD_FALL)) begin
            next_shreg = justify(result_o);
        end else if (fall_evt) begin
            next_shreg = {shreg[WB-2:0], 1'b0};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shreg <= sar_seq_pkg::WORD_RESET;
        end else begin
            shreg <= next_shreg;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_o <= !cs_sync && next_shreg[WB-1];
            sdo_oe_o <= !cs_sync;
        end
    end

    // ****************************************************
    // Frame length detection
    // ****************************************************
    // Set only while chip-select is low, cleared only at a frame start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            long_frame_o <= 1'b0;
        end else if (fall_evt && (fall_bin == sar_seq_pkg::LONG_FRAME_FALL)) begin
            long_frame_o <= 1'b1;
        end else if (frame_start) begin
            long_frame_o <= 1'b0;
        end
    end

    // ****************************************************
    // Power control
    // ****************************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_armed <= 1'b0;
        end else if (frame_end) begin
            pd_armed <= pd_sync;
        end
    end

    always_comb begin
        next_pwr = pwr;
        case (pwr)
            sar_seq_pkg::PWR_ACTIVE: begin
                if (conv_done && pd_armed) begin
                    next_pwr = sar_seq_pkg::PWR_ASLEEP;
                end
            end
            sar_seq_pkg::PWR_ASLEEP: begin
                // Only a frame end can wake, never an edge inside the frame
                if (frame_end && (!pd_sync || long_frame_o)) begin
                    next_pwr = sar_seq_pkg::PWR_WAKING;
                end
            end
            sar_seq_pkg::PWR_WAKING: begin
                if (conv_done && pd_armed) begin
                    next_pwr = sar_seq_pkg::PWR_ASLEEP;
                end else if (wake_cnt == sar_seq_pkg::WAKE_CNT_RESET) begin
                    next_pwr = sar_seq_pkg::PWR_ACTIVE;
                end
            end
            default: begin
                next_pwr = sar_seq_pkg::PWR_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr <= sar_seq_pkg::PWR_ACTIVE;
        end else begin
            pwr <= next_pwr;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt <= sar_seq_pkg::WAKE_CNT_RESET;
        end else if (pwr != sar_seq_pkg::PWR_WAKING) begin
            wake_cnt <= sar_seq_pkg::WAKE_CNT_LOAD;
        end else if (wake_cnt != sar_seq_pkg::WAKE_CNT_RESET) begin
            wake_cnt <= wake_cnt - 7'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            powered_down_o <= 1'b0;
            fully_powered_o <= 1'b1;
        end else begin
            powered_down_o <= (next_pwr == sar_seq_pkg::PWR_ASLEEP);
            fully_powered_o <= (next_pwr == sar_seq_pkg::PWR_ACTIVE);
        end
    end

endmodule // sar_adc_frame_sequencer

// [sar_seq_pkg.sv]
// Shared constants, types and gray-code helpers for the SAR frame sequencer.
// Assumes a 100 MHz core clock and a host-driven serial clock.
package sar_seq_pkg;

    // ****************************************************
    // Widths and frame edges
    // ****************************************************
    localparam int RESOLUTION = 12;
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 6;
    localparam logic [5:0] CONV_DONE_RISE = (RESOLUTION == 12) ? 6'h0e :
                                            (RESOLUTION == 10) ? 6'h0b : 6'h09;
    localparam logic [5:0] CONV_FIRST_RISE = CONV_DONE_RISE - 6'(RESOLUTION) + 6'h01;
    localparam logic [5:0] RELOAD_FALL = 6'h10;
    localparam logic [5:0] LONG_FRAME_FALL = 6'h1e;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [5:0] CNT_RESET = 6'h00;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    // ****************************************************
    // Wake-up timing
    // ****************************************************
    localparam int REF_CLK_PERIOD_NS = 10;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam logic [6:0] WAKE_CNT_LOAD = 7'(WAKE_CYCLES - 1);
    localparam logic [6:0] WAKE_CNT_RESET = 7'h00;

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_ASLEEP, PWR_WAKING} power_state_t;

    function automatic logic [CNT_BITS-1:0] gray_to_bin(input logic [CNT_BITS-1:0] g);
        logic [CNT_BITS-1:0] b;
        b[CNT_BITS-1] = g[CNT_BITS-1];
        for (int i = CNT_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    function automatic logic [CNT_BITS-1:0] bin_to_gray(input logic [CNT_BITS-1:0] b);
        return b ^ (b >> 1);
    endfunction

endpackage

// [sar_seq_sva.sv]
// Port-level checks of the SAR frame sequencer.
// Assumes binding to sar_adc_frame_sequencer; reset is asynchronous, active low.
module sar_seq_sva (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic power_down_request_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic [11:0] result_o,
    input wire logic powered_down_o,
    input wire logic fully_powered_o,
    input wire logic converting_o,
    input wire logic acquiring_o,
    input wire logic long_frame_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // ****************************************************
    // Wake-up cycle counter
    // ****************************************************
    logic [7:0] wake_cnt;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt <= 8'h00;
        end else if (powered_down_o || fully_powered_o) begin
            wake_cnt <= 8'h00;
        end else begin
            wake_cnt <= wake_cnt + 8'h01;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    AST_OE_ON: assert property ($fell(cs_b_i) |-> ##[2:5] sdo_oe_o)
        else $error("output not enabled after frame start");
    AST_CONV_START: assert property ($fell(cs_b_i) |-> ##[2:5] converting_o)
        else $error("conversion not started after frame start");
    AST_OE_OFF: assert property (cs_b_i [*5] |-> !sdo_oe_o)
        else $error("output enabled while deselected");
    AST_SDO_IDLE: assert property (!sdo_oe_o |-> !sdo_o)
        else $error("serial data not parked while released");
    AST_SLEEP_AT_END: assert property ($rose(powered_down_o) |-> $fell(converting_o) && acquiring_o)
        else $error("sleep entered away from conversion end");
    AST_SLEEP_FLAGS: assert property (powered_down_o |-> !fully_powered_o)
        else $error("asleep and fully powered together");
    AST_SLEEP_HOLD: assert property (powered_down_o && !cs_b_i |=> powered_down_o)
        else $error("woke while selected");
    AST_WAKE_ON_CS: assert property ($rose(cs_b_i) && powered_down_o && !power_down_request_i
        |-> ##[2:5] !powered_down_o)
        else $error("no wake on deselect with request low");
    AST_WAKE_TIME: assert property ($rose(fully_powered_o) |-> wake_cnt >= 8'h60 && wake_cnt <= 8'h66)
        else $error("wake-up time not one microsecond");
    AST_RESULT_AT_END: assert property ($changed(result_o) |-> $fell(converting_o))
        else $error("result changed away from conversion end");
    AST_ACQ_AFTER_CONV: assert property ($fell(converting_o) |-> acquiring_o)
        else $error("acquisition not started at conversion end");
    AST_LONG_CLEAR: assert property (long_frame_o && $fell(cs_b_i) |-> ##[2:5] !long_frame_o)
        else $error("long mode flag not cleared at frame start");

    COV_LONG: cover property ($rose(long_frame_o));
    COV_SLEEP: cover property ($rose(powered_down_o));
    COV_WAKE: cover property ($rose(fully_powered_o));
endmodule // sar_seq_sva

bind sar_adc_frame_sequencer sar_seq_sva sar_seq_sva_inst (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .power_down_request_i(power_down_request_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .result_o(result_o), .powered_down_o(powered_down_o), .fully_powered_o(fully_powered_o),
    .converting_o(converting_o), .acquiring_o(acquiring_o), .long_frame_o(long_frame_o)
);

// [tb_top.sv]
// Self-checking bench of the SAR frame sequencer with a host model on the link.
// Assumes the checker is bound in; the run stays well under 40000 core cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk_i, rst_b_i, sclk, cs_b, pd_req, sdo, sdo_oe;
    logic powered_down, fully_powered, converting, acquiring, long_frame;
    logic [11:0] sample, result, prev;
    logic prev_long;
    logic [31:0] cap;
    int failures, n_tests, cycles;
    int fixed[7] = '{16, 32, 16, 29, 12, 16, 14};
    int lens[5] = '{16, 29, 32, 14, 20};

    host_model host_model_inst (.cs_b_o(cs_b), .sclk_o(sclk), .pd_req_o(pd_req), .sdo_i(sdo));

    sar_adc_frame_sequencer sar_adc_frame_sequencer_inst (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
        .power_down_request_i(pd_req), .sample_value_i(sample), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .result_o(result), .powered_down_o(powered_down), .fully_powered_o(fully_powered),
        .converting_o(converting), .acquiring_o(acquiring), .long_frame_o(long_frame)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // ****************************************************
    // Expectations and comparisons
    // ****************************************************
    function automatic logic [31:0] exp_stream(input logic [11:0] p, input logic [11:0] c, input logic lng);
        return {(lng ? 16'h0000 : {p, 4'h0}), c, 4'h0};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic run(input int n, input logic pd);
        logic [11:0] val;
        int sh;
        val = 12'($urandom);
        sh = 32 - n;
        @(posedge ref_clk_i);
        #1 sample = val;
        repeat (5) @(posedge ref_clk_i);
        // Link edges start off the core clock's sampling edge
        #1;
        host_model_inst.frame(n, pd, cap);
        repeat (6) @(posedge ref_clk_i);
        #1;
        check(cap >> sh, exp_stream(prev, val, prev_long) >> sh);
        check({31'h0, sdo_oe}, 32'h0000_0000);
        check({31'h0, long_frame}, {31'h0, n >= 30});
        check({30'h0, converting, acquiring}, 32'h0000_0001);
        if (n >= 14) begin
            check({20'h0, result}, {20'h0, val});
            prev = val;
        end
        prev_long = (n >= 30);
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        rst_b_i = 1'b0;
        sample = 12'h000;
        prev = 12'h000;
        prev_long = 1'b0;
        failures = 0;
        n_tests = 0;
        cycles = 0;
        void'($urandom(21));
        repeat (10) @(posedge ref_clk_i);
        #1 rst_b_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        for (int i = 0; i < 7; i++) begin
            run(fixed[i], 1'b0);
        end
        // Arm, sleep, read out while asleep, then wake
        run(16, 1'b1);
        run(16, 1'b1);
        check({31'h0, powered_down}, 32'h0000_0001);
        check({31'h0, fully_powered}, 32'h0000_0000);
        run(16, 1'b0);
        check({31'h0, powered_down}, 32'h0000_0000);
        check({31'h0, fully_powered}, 32'h0000_0000);
        repeat (110) @(posedge ref_clk_i);
        #1;
        check({31'h0, fully_powered}, 32'h0000_0001);
        repeat (50) @(posedge ref_clk_i);
        for (int i = 0; i < 12; i++) begin
            run(lens[$urandom % 5], 1'b0);
        end
        // Long frames with power-down: sleep at conversion end, wake at the frame's end
        run(32, 1'b1);
        run(32, 1'b1);
        check({30'h0, powered_down, fully_powered}, 32'h0000_0000);
        repeat (110) @(posedge ref_clk_i);
        #1;
        check({31'h0, fully_powered}, 32'h0000_0001);
        stop_test();
    end
endmodule // tb_top
